// ==== test/irq_ctrl_with_wide_timer_bench.sv ====
// self-checking bench of the interrupt block with its wide timer
// assumes irqwt_top with a classic wishbone slave answering in one wait state
`timescale 1ns/10ps
`default_nettype none
`include "irqwt_defines.svh"
module irq_ctrl_with_wide_timer_bench;
  import irqwt_pkg::*;

  localparam logic [7:0] A_EN  = {`IRQWT_IDX_ENABLE, 2'b00};
  localparam logic [7:0] A_RQ  = {`IRQWT_IDX_REQUEST, 2'b00};
  localparam logic [7:0] A_TM  = {`IRQWT_IDX_TMODE, 2'b00};
  localparam logic [7:0] A_CNT = {`IRQWT_IDX_COUNT, 2'b00};
  localparam logic [7:0] A_CLR = {`IRQWT_IDX_CLEAR, 2'b00};
  localparam logic [7:0] A_EDG = {`IRQWT_IDX_EDGE, 2'b00};
  localparam logic [7:0] A_PIE = {`IRQWT_IDX_PIN_IE, 2'b00};

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, irq;
  logic        t3 = 1'b0, t2 = 1'b0, pwm = 1'b0, cmp = 1'b0;
  logic        p0 = 1'b0, p4 = 1'b0, p5 = 1'b0, fosc = 1'b0, sosc = 1'b0;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [31:0] v, c1, c2;

  irqwt_top uut (
    .clk_sys_in(clk), .rst_in(rst),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .timer3_evt_in(t3), .timer2_evt_in(t2), .low_power_pwm_evt_in(pwm),
    .analog_comparator_in(cmp), .port_a_pin0_in(p0), .port_a_pin4_in(p4),
    .port_a_pin5_in(p5), .fast_internal_rc_osc_in(fosc),
    .slow_internal_rc_osc_in(sosc), .irq_out(irq)
  );

  // 10 mhz system clock
  always #50 clk = ~clk;

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 40000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; ack is sampled at the edge, release follows it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    check("bus wait states", n, 32'h1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, 4'hf, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 8'h00, 4'hf, r);
  endtask

  // drive one of the asynchronous levels, then let the synchroniser settle
  task automatic lvl(input int t, input logic x);
    case (t)
      0: cmp <= x;
      1: p0 <= x;
      2: p5 <= x;
      3: p4 <= x;
      4: fosc <= x;
      5: sosc <= x;
      default: p0 <= x;
    endcase
    repeat (6) @(posedge clk);
  endtask

  // run the timer w cycles; span and tap event both follow from the counts read
  task automatic run_tmr(input logic [1:0] dv, input logic [2:0] tp, input logic ed, input int w);
    logic [31:0] r;
    logic [15:0] a, b, sp;
    logic        ex;
    int          d;
    wr(A_EDG, {3'b000, ed, 4'h0});
    wr(A_TM, {3'b000, dv, tp});
    rd(A_CNT, c1);
    wr(A_CLR, 8'h04);
    wr(A_TM, {3'b001, dv, tp});
    repeat (w) @(posedge clk);
    wr(A_TM, {3'b000, dv, tp});
    rd(A_CNT, c2);
    rd(A_RQ, r);
    d  = 1 << (2 * dv);
    sp = c2[15:0] - c1[15:0];
    ex = 1'b0;
    for (a = c1[15:0]; a != c2[15:0]; a++) begin
      b = a + 16'h0001;
      if (ed ? (a[8 + tp] && !b[8 + tp]) : (!a[8 + tp] && b[8 + tp])) ex = 1'b1;
    end
    check("timer span", {16'h0, sp}, 32'((w + 3) / d));
    check("timer tap request", {31'h0, r[2]}, {31'h0, ex});
  endtask

  initial begin
    logic [2:0] codes [3];
    logic [2:0] ext [4];
    codes = '{3'b000, 3'b010, 3'b101};
    ext   = '{3'b011, 3'b100, 3'b110, 3'b111};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and refused reads
    rd(A_EN, v);  check("enable reset", v, 32'h0);
    rd(A_RQ, v);  check("request reset", v, 32'h0);
    rd(A_TM, v);  check("timer mode reset", v, 32'h0);
    rd(A_EDG, v); check("edge select read", v, 32'h0);
    rd(8'h3c, v); check("unmapped read", v, 32'h0);
    // enable layout, reserved bits stay zero
    wr(A_EN, 8'hff);
    rd(A_EN, v); check("enable mask", v, 32'h000000f5);
    wr(A_EN, 8'h00);
    xfer(1'b1, A_EN, 8'h04, 4'he, v);
    rd(A_EN, v); check("enable lane off", v, 32'h0);
    // sticky peripheral requests and the level interrupt
    t3 <= 1'b1; t2 <= 1'b1; pwm <= 1'b1;
    @(posedge clk);
    t3 <= 1'b0; t2 <= 1'b0; pwm <= 1'b0;
    repeat (20) @(posedge clk);
    rd(A_RQ, v); check("peripheral requests", v, 32'h000000e0);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(A_EN, 8'h40);
    repeat (2) @(posedge clk);
    check("irq enabled", {31'h0, irq}, 32'h1);
    wr(A_RQ, 8'hbf);
    rd(A_RQ, v); check("request write zero", v, 32'h000000a0);
    check("irq after clear", {31'h0, irq}, 32'h0);
    wr(A_CLR, 8'hff);
    rd(A_RQ, v); check("clear register", v, 32'h0);
    // comparator and pin edge modes, every code
    for (int t = 0; t < 3; t++) begin
      for (int m = 0; m < 4; m++) begin
        wr(A_EDG, (t == 0) ? 8'(m << 6) : 8'(m));
        wr(A_CLR, 8'hff);
        lvl(t, 1'b1);
        rd(A_RQ, v);
        check("rising edge request", {31'h0, v[(t == 0) ? 4 : 0]}, 32'(m < 2));
        wr(A_CLR, 8'hff);
        lvl(t, 1'b0);
        rd(A_RQ, v);
        check("falling edge request", {31'h0, v[(t == 0) ? 4 : 0]}, 32'(m == 0 || m == 2));
      end
    end
    // pin input enable gates the shared pin request
    wr(A_EDG, 8'h00);
    wr(A_PIE, 8'h20);
    wr(A_CLR, 8'hff);
    lvl(1, 1'b1);
    lvl(1, 1'b0);
    rd(A_RQ, v); check("pin0 disabled", v, 32'h0);
    lvl(2, 1'b1);
    rd(A_RQ, v); check("pin5 enabled", v, 32'h00000001);
    lvl(2, 1'b0);
    wr(A_PIE, 8'h01);
    wr(A_CLR, 8'hff);
    lvl(2, 1'b1);
    lvl(2, 1'b0);
    rd(A_RQ, v); check("pin5 disabled", v, 32'h0);
    wr(A_PIE, 8'h00);
    lvl(1, 1'b1);
    lvl(1, 1'b0);
    rd(A_RQ, v); check("both pins disabled", v, 32'h0);
    wr(A_PIE, 8'h21);
    // halting codes store but do not count
    foreach (codes[i]) begin
      wr(A_TM, {codes[i], 5'h00});
      rd(A_CNT, c1);
      repeat (50) @(posedge clk);
      rd(A_CNT, c2); check("halted count", c2, c1);
      rd(A_TM, v);   check("timer mode readback", v, {24'h0, codes[i], 5'h00});
    end
    // external and oscillator sources count their own edges
    foreach (ext[i]) begin
      wr(A_TM, {ext[i], 5'h07});
      rd(A_CNT, c1);
      repeat (5) begin
        lvl(3 + i, 1'b1);
        lvl(3 + i, 1'b0);
      end
      rd(A_CNT, c2);
      check("external ticks", {16'h0, c2[15:0] - c1[15:0]}, 32'h5);
      wr(A_TM, 8'h00);
    end
    // prescaler codes, then every tap, rising on even and falling on odd taps, and tap 0 falling
    for (int dv = 0; dv < 4; dv++) run_tmr(2'(dv), 3'd0, 1'b0, 640);
    for (int tp = 0; tp < 8; tp++) run_tmr(2'b00, 3'(tp), 1'(tp), 300);
    run_tmr(2'b00, 3'd0, 1'b1, 600);
    // second reset mid-run restores every reset value
    wr(A_EN, 8'hf5);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(A_EN, v); check("enable after reset", v, 32'h0);
    rd(A_RQ, v); check("request after reset", v, 32'h0);
    check("irq after reset", {31'h0, irq}, 32'h0);
    lvl(1, 1'b1);
    rd(A_RQ, v); check("pin edge after reset", v, 32'h00000001);
    stop_test();
  end

endmodule
`default_nettype wire

// ==== verilog/irqwt_defines.svh ====
// register map, field positions and reset values of the interrupt block
// assumes a 32-bit wishbone slave; byte address is four times the index
`ifndef IRQWT_DEFINES_SVH
`define IRQWT_DEFINES_SVH

// register indices
`define IRQWT_IDX_ENABLE  6'h04
`define IRQWT_IDX_REQUEST 6'h05
`define IRQWT_IDX_TMODE   6'h06
`define IRQWT_IDX_COUNT   6'h07
`define IRQWT_IDX_CLEAR   6'h08
`define IRQWT_IDX_EDGE    6'h0c
`define IRQWT_IDX_PIN_IE  6'h0d

// implemented request and enable bits
`define IRQWT_SRC_MASK    8'hf5

// field positions
`define IRQWT_BIT_TMR3    7
`define IRQWT_BIT_TMR2    6
`define IRQWT_BIT_PWM     5
`define IRQWT_BIT_CMP     4
`define IRQWT_BIT_WTMR    2
`define IRQWT_BIT_PIN     0
`define IRQWT_BIT_TEDGE   4
`define IRQWT_BIT_PIN5_IE 5
`define IRQWT_BIT_PIN0_IE 0

// reset values
`define IRQWT_RST_ENABLE  8'h00
`define IRQWT_RST_TMODE   8'h00
`define IRQWT_RST_EMODE   2'h0
`define IRQWT_RST_PIN_IE  1'b1

`endif

// ==== verilog/irqwt_edge_sync.sv ====
// synchroniser and edge detector for a vector of asynchronous inputs
// assumes inputs change slower than half the system clock
`timescale 1ns/10ps
`default_nettype none
module irqwt_edge_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // asynchronous levels and their edges
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      logic last_r;
      // first stage feeds only the second
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          last_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
          last_r <= sync_r;
        end
      end
      assign rise_out[i] = sync_r & ~last_r;
      assign fall_out[i] = ~sync_r & last_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== verilog/irqwt_pkg.sv ====
// types shared by the interrupt block modules
// no dependencies
package irqwt_pkg;

  // wide timer clock source codes
  typedef enum logic [2:0] {
    IRQWT_SRC_OFF  = 3'b000,
    IRQWT_SRC_SYS  = 3'b001,
    IRQWT_SRC_P4F  = 3'b011,
    IRQWT_SRC_FAST = 3'b100,
    IRQWT_SRC_SLOW = 3'b110,
    IRQWT_SRC_P0F  = 3'b111
  } irqwt_src_t;

  // edge modes of comparator and pin requests
  typedef enum logic [1:0] {
    IRQWT_EDGE_BOTH = 2'b00,
    IRQWT_EDGE_RISE = 2'b01,
    IRQWT_EDGE_FALL = 2'b10,
    IRQWT_EDGE_NONE = 2'b11
  } irqwt_edge_t;

endpackage

// ==== verilog/irqwt_prescale.sv ====
// divider of a tick stream by 1, 4, 16 or 64
// assumes tick_in is a one-cycle enable on the system clock
`timescale 1ns/10ps
`default_nettype none
module irqwt_prescale (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // control
  input  wire logic       run_in,
  input  wire logic [1:0] div_in,
  // ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [5:0] cnt_r;
  logic [5:0] mask;

  // divide mask per code
  always_comb begin
    case (div_in)
      2'h0:    mask = 6'h00;
      2'h1:    mask = 6'h03;
      2'h2:    mask = 6'h0f;
      default: mask = 6'h3f;
    endcase
  end

  // stopped source restarts from a clean phase
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      cnt_r <= 6'h00;
    end else if (tick_in) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  assign tick_out = run_in & tick_in & ((cnt_r & mask) == mask);

endmodule
`default_nettype wire

// ==== verilog/irqwt_top.sv ====
// interrupt request logic with a wide timer, wishbone register slave
// assumes a classic wishbone master on clk_sys_in, pins from outside it
`timescale 1ns/10ps
`default_nettype none
`include "irqwt_defines.svh"
module irqwt_top
  import irqwt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // events from on-chip peripherals
  input  wire logic        timer3_evt_in,
  input  wire logic        timer2_evt_in,
  input  wire logic        low_power_pwm_evt_in,
  // asynchronous levels
  input  wire logic        analog_comparator_in,
  input  wire logic        port_a_pin0_in,
  input  wire logic        port_a_pin4_in,
  input  wire logic        port_a_pin5_in,
  input  wire logic        fast_internal_rc_osc_in,
  input  wire logic        slow_internal_rc_osc_in,
  // interrupt to the core
  output logic             irq_out
);

  logic [7:0]  enable_r;
  logic [7:0]  request_r;
  logic [7:0]  tmode_r;
  logic [1:0]  cmp_mode_r;
  logic [1:0]  pin_mode_r;
  logic        tedge_r;
  logic        pin0_ie_r;
  logic        pin5_ie_r;
  logic [15:0] count_r;
  logic        tap_last_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        irq_r;
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic        raw_tick;
  logic        cnt_tick;
  logic        tmr_run;
  logic        tap_bit;
  logic        tap_evt;
  logic        cmp_evt;
  logic        pin_evt;
  logic [7:0]  set_vec;
  logic [7:0]  clr_mask;
  logic [31:0] rd_nxt;
  logic        bus_req;
  logic        wr;
  logic [5:0]  idx;
  logic [7:0]  wd;
  irqwt_src_t  src;

  // bus decode; writes land on the edge that sees ack high
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign idx     = wb_adr_in[7:2];
  assign wd      = wb_dat_in[7:0];
  assign wr      = bus_req & ack_r & wb_we_in & wb_sel_in[0];

  // one synchroniser bank for every outside level
  irqwt_edge_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({slow_internal_rc_osc_in, fast_internal_rc_osc_in, port_a_pin5_in,
                  port_a_pin4_in, port_a_pin0_in, analog_comparator_in}),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // edge mode match; reserved code never fires
  function automatic logic edge_hit(input logic [1:0] mode, input logic r, input logic f);
    case (irqwt_edge_t'(mode))
      IRQWT_EDGE_BOTH: edge_hit = r | f;
      IRQWT_EDGE_RISE: edge_hit = r;
      IRQWT_EDGE_FALL: edge_hit = f;
      default:         edge_hit = 1'b0;
    endcase
  endfunction

  // timer clock source; oscillators are sampled, so only slow ones count true
  assign src = irqwt_src_t'(tmode_r[7:5]);
  always_comb begin
    case (src)
      IRQWT_SRC_SYS:  raw_tick = 1'b1;
      IRQWT_SRC_P4F:  raw_tick = fall[2];
      IRQWT_SRC_FAST: raw_tick = rise[4];
      IRQWT_SRC_SLOW: raw_tick = rise[5];
      IRQWT_SRC_P0F:  raw_tick = fall[1];
      default:        raw_tick = 1'b0;
    endcase
  end
  assign tmr_run = (raw_tick | (src != IRQWT_SRC_OFF)) && (src != IRQWT_SRC_OFF);

  irqwt_prescale u_presc (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .run_in     (tmr_run),
    .div_in     (tmode_r[4:3]),
    .tick_in    (raw_tick),
    .tick_out   (cnt_tick)
  );

  // wide timer counter, wraps naturally
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_r <= 16'h0000;
    end else if (cnt_tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // tap bit 8 plus the tap code
  assign tap_bit = count_r[{1'b1, tmode_r[2:0]}];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tap_last_r <= 1'b0;
    end else begin
      tap_last_r <= tap_bit;
    end
  end
  // a tap code change may also flip the bit; that counts as a change too
  assign tap_evt = tedge_r ? (tap_last_r & ~tap_bit) : (~tap_last_r & tap_bit);

  // comparator and gated pin events
  assign cmp_evt = edge_hit(cmp_mode_r, rise[0], fall[0]);
  assign pin_evt = (pin0_ie_r & edge_hit(pin_mode_r, rise[1], fall[1])) |
                   (pin5_ie_r & edge_hit(pin_mode_r, rise[3], fall[3]));

  // reserved positions stay zero
  always_comb begin
    set_vec                    = 8'h00;
    set_vec[`IRQWT_BIT_TMR3]   = timer3_evt_in;
    set_vec[`IRQWT_BIT_TMR2]   = timer2_evt_in;
    set_vec[`IRQWT_BIT_PWM]    = low_power_pwm_evt_in;
    set_vec[`IRQWT_BIT_CMP]    = cmp_evt;
    set_vec[`IRQWT_BIT_WTMR]   = tap_evt;
    set_vec[`IRQWT_BIT_PIN]    = pin_evt;
  end

  // writing 0 to the request register or 1 to the clear register drops a flag
  always_comb begin
    clr_mask = 8'h00;
    if (wr && idx == `IRQWT_IDX_REQUEST) begin
      clr_mask = ~wd & `IRQWT_SRC_MASK;
    end else if (wr && idx == `IRQWT_IDX_CLEAR) begin
      clr_mask = wd & `IRQWT_SRC_MASK;
    end
  end

  // sticky requests; a set in the clear cycle wins
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      request_r <= 8'h00;
    end else begin
      request_r <= ((request_r & ~clr_mask) | set_vec) & `IRQWT_SRC_MASK;
    end
  end

  // enable register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      enable_r <= `IRQWT_RST_ENABLE;
    end else if (wr && idx == `IRQWT_IDX_ENABLE) begin
      enable_r <= wd & `IRQWT_SRC_MASK;
    end
  end

  // timer mode; reserved source codes are kept but stop the timer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tmode_r <= `IRQWT_RST_TMODE;
    end else if (wr && idx == `IRQWT_IDX_TMODE) begin
      tmode_r <= wd;
    end
  end

  // write-only edge select, reserved bits are not stored
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cmp_mode_r <= `IRQWT_RST_EMODE;
      pin_mode_r <= `IRQWT_RST_EMODE;
      tedge_r    <= 1'b0;
    end else if (wr && idx == `IRQWT_IDX_EDGE) begin
      cmp_mode_r <= wd[7:6];
      tedge_r    <= wd[`IRQWT_BIT_TEDGE];
      pin_mode_r <= wd[1:0];
    end
  end

  // pin digital input enables, write-only
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin0_ie_r <= `IRQWT_RST_PIN_IE;
      pin5_ie_r <= `IRQWT_RST_PIN_IE;
    end else if (wr && idx == `IRQWT_IDX_PIN_IE) begin
      pin0_ie_r <= wd[`IRQWT_BIT_PIN0_IE];
      pin5_ie_r <= wd[`IRQWT_BIT_PIN5_IE];
    end
  end

  // read mux; write-only and unmapped words read zero
  always_comb begin
    case (idx)
      `IRQWT_IDX_ENABLE:  rd_nxt = {24'h000000, enable_r};
      `IRQWT_IDX_REQUEST: rd_nxt = {24'h000000, request_r};
      `IRQWT_IDX_TMODE:   rd_nxt = {24'h000000, tmode_r};
      `IRQWT_IDX_COUNT:   rd_nxt = {16'h0000, count_r};
      default:            rd_nxt = 32'h00000000;
    endcase
  end

  // one wait state: data captured on the first request cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req && !ack_r) begin
        dat_r <= rd_nxt;
      end
    end
  end

  // interrupt level, one cycle behind the flags
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(request_r & enable_r);
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;
  assign irq_out    = irq_r;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence bus_start_s;
    bus_req && !ack_r;
  endsequence
  sequence bus_done_s;
    ack_r ##1 !ack_r;
  endsequence
  // a pending enabled request must reach the core one cycle later
  sequence pend_s;
    (request_r & enable_r) != 8'h00;
  endsequence

  bus_ack_once_a: assert property (bus_start_s |=> bus_done_s)
    else $error("ack is not a single pulse one cycle after request");
  reserved_zero_a: assert property ((enable_r[3] | enable_r[1] | request_r[3] | request_r[1]) == 1'b0)
    else $error("reserved enable or request bit set");
  req_set_a: assert property ((set_vec != 8'h00) |=> ((request_r & $past(set_vec)) == $past(set_vec)))
    else $error("event did not set its request flag");
  req_hold_a: assert property (1'b1 |=>
    (request_r & $past(request_r & ~clr_mask)) == $past(request_r & ~clr_mask))
    else $error("request flag dropped without a software clear");
  irq_level_a: assert property (##1 irq_out == $past(|(request_r & enable_r)))
    else $error("interrupt output does not follow flags and enables");
  cnt_step_a: assert property (cnt_tick |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step on tick");
  cnt_still_a: assert property (!cnt_tick |=> $stable(count_r))
    else $error("counter moved without tick");
  timer_off_a: assert property (src == IRQWT_SRC_OFF |-> !cnt_tick)
    else $error("disabled timer ticked");
  tap_edge_a: assert property (tap_evt |-> (tap_bit == !tedge_r) && (tap_last_r != tap_bit))
    else $error("timer event without matching tap edge");
  pin_gate_a: assert property (!pin0_ie_r && !pin5_ie_r |-> !pin_evt)
    else $error("pin request while both inputs disabled");
  cmp_reserved_a: assert property (cmp_mode_r == 2'b11 |-> !cmp_evt)
    else $error("comparator request in reserved mode");
  div_one_a: assert property (tmode_r[4:3] == 2'b00 && raw_tick && tmr_run |-> cnt_tick)
    else $error("divide by one dropped a tick");
  // a clear that meets no event of its own must drop the flag
  req_drop_a: assert property ((clr_mask & ~set_vec) != 8'h00 |=>
    (request_r & $past(clr_mask & ~set_vec)) == 8'h00)
    else $error("cleared request flag stayed set");
  irq_follow_a: assert property (pend_s |=> irq_out)
    else $error("interrupt output low with an enabled request");
  enable_wr_a: assert property (wr && idx == `IRQWT_IDX_ENABLE |=>
    enable_r == ($past(wd) & `IRQWT_SRC_MASK))
    else $error("enable write did not land");
  pin5_gate_a: assert property (!pin5_ie_r && !rise[1] && !fall[1] |-> !pin_evt)
    else $error("pin request from a disabled pin5 input");

endmodule
`default_nettype wire
